/* rtl/hc_cmd_if.sv */
// Command port joining the host-side master and the register bank
`timescale 1ns/1ps
interface hc_cmd_if;
  logic cmdValid;
  hc_regs_pkg::cmd_t cmdCode;
  hc_regs_pkg::word_t cmdWdata;
  logic cmdDone;
  hc_regs_pkg::word_t cmdRdata;
  modport device (input cmdValid, input cmdCode, input cmdWdata,
    output cmdDone, output cmdRdata);
  modport host (output cmdValid, output cmdCode, output cmdWdata,
    input cmdDone, input cmdRdata);
endinterface

/* rtl/hc_host_master.sv */
// Host end: APB-programmed master issuing register commands
`timescale 1ns/1ps
`include "hc_regs_defines.svh"
module hc_host_master (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  hc_cmd_if.host cmdPort // Command port
);
  import hc_regs_pkg::*;

  host_state_t state_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic cmdValid_r;
  logic [7:0] cmdCode_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic busy;
  logic apbWr;
  logic startCmd;
  logic [31:0] rdSel;
  logic mapped;

  // APB decode; writes act at the edge that completes the transfer with pready
  assign apbWr = psel && penable && pwrite && pready_r;
  assign busy = state_r != HS_IDLE;
  // go bit written as a set pulse
  assign startCmd = apbWr && paddr == `APB_CTRL_OFS && pwdata[`CTRL_GO_BIT] && !busy;
  assign mapped = paddr == `APB_CTRL_OFS || paddr == `APB_STAT_OFS
    || paddr == `APB_WDATA_OFS || paddr == `APB_RDATA_OFS;
  // data words passed whole; control and status read zero outside their fields
  assign rdSel = (paddr == `APB_CTRL_OFS) ? {16'h0000, cmdCode_r, 8'h00} :
    (paddr == `APB_STAT_OFS) ? {31'h00000000, busy} :
    (paddr == `APB_WDATA_OFS) ? wdata_r :
    (paddr == `APB_RDATA_OFS) ? rdata_r : 32'h00000000;

  // APB slave registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      wdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      prdata_r <= (psel && penable && !pwrite) ? rdSel : 32'h00000000;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      // software stages the full word it read and modified
      if (apbWr && paddr == `APB_WDATA_OFS) begin
        wdata_r <= pwdata;
      end
    end
  end

  // Command sequencer
  // writes carry the staged shadow word unchanged
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= HS_IDLE;
      cmdValid_r <= 1'b0;
      cmdCode_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end else begin
      case (state_r)
        HS_IDLE: begin
          if (startCmd) begin
            cmdCode_r <= {pwdata[`CTRL_WR_BIT], pwdata[`CTRL_CMD_MSB - 1:`CTRL_CMD_LSB]};
            cmdValid_r <= 1'b1;
            state_r <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (cmdPort.cmdDone) begin
            cmdValid_r <= 1'b0;
            rdata_r <= cmdPort.cmdRdata;
            state_r <= HS_DONE;
          end
        end
        HS_DONE: begin
          state_r <= HS_IDLE;
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign cmdPort.cmdValid = cmdValid_r;
  assign cmdPort.cmdCode = cmdCode_r;
  assign cmdPort.cmdWdata = wdata_r;
endmodule

/* rtl/hc_reg_bank.sv */
// Command-addressed host controller register bank, device end
`timescale 1ns/1ps
`include "hc_regs_defines.svh"
module hc_reg_bank #(
  parameter logic [15:0] CHIP_ID = 16'h5a5a // Arbitrary identification value
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  hc_cmd_if.device cmdPort, // Command port
  output logic softResetPulse // Soft reset trigger seen
);
  import hc_regs_pkg::*;

  // Writable storage, indexed by the seven-bit address
  logic [31:0] regMem_r [0:127];
  logic cmdDone_r;
  logic [31:0] cmdRdata_r;
  logic softReset_r;
  logic [6:0] addr;
  logic take;
  logic isWrite;
  logic isRo;
  logic isMapped;
  logic isWide;
  logic isOper32;
  logic isList32;
  logic isNarrow;
  logic wrEn;
  logic [31:0] wrWord;
  logic [31:0] rdNarrow;
  logic [31:0] rdStored;
  logic [31:0] rdVal;
  // Operational register selects
  logic hitRev;
  logic hitCtrl;
  logic hitCmdSt;
  logic hitEvFlg;
  logic hitEvSet;
  logic hitEvClr;
  logic hitFmInt;
  logic hitFmLeft;
  logic hitFmNum;
  logic hitLsTh;
  logic hitRhA;
  logic hitRhB;
  logic hitRhSt;
  logic hitPort1;
  logic hitPort2;
  // List register selects
  logic hitPDone;
  logic hitPSkip;
  logic hitPLast;
  logic hitPAct;
  logic hitADone;
  logic hitASkip;
  logic hitALast;
  logic hitAAct;
  // Other register selects
  logic hitHwCfg;
  logic hitDmaCfg;
  logic hitXferCnt;
  logic hitCpuEv;
  logic hitCpuEn;
  logic hitPartId;
  logic hitScratch;
  logic hitSwRst;
  logic hitBufSt;
  logic hitIsoLen;
  logic hitDaLen;
  logic hitPLen;
  logic hitALen;
  logic hitIso0Win;
  logic hitIso1Win;
  logic hitPWin;
  logic hitAWin;
  logic hitDaWord;
  logic hitIsoRate;
  logic hitADCnt;
  logic hitADTime;
  logic hitPBlk;
  logic hitABlk;

  // Command decode: bit 7 selects write, low bits the address
  // read/write code pairs
  assign addr = cmdPort.cmdCode[6:0];
  assign isWrite = (cmdPort.cmdCode & `HC_WR_FLAG) != 8'h00;
  // A command is taken once; the held request must not act again
  assign take = cmdPort.cmdValid && !cmdDone_r;

  // Operational set at the open interface offsets over four
  // address equals offset over four
  assign hitRev = addr == `HC_CMD_REV;
  assign hitCtrl = addr == `HC_CMD_CTRL;
  assign hitCmdSt = addr == `HC_CMD_CMDST;
  assign hitEvFlg = addr == `HC_CMD_EVFLG;
  assign hitEvSet = addr == `HC_CMD_EVSET;
  assign hitEvClr = addr == `HC_CMD_EVCLR;
  assign hitFmInt = addr == `HC_CMD_FMINT;
  assign hitFmLeft = addr == `HC_CMD_FMLEFT;
  assign hitFmNum = addr == `HC_CMD_FMNUM;
  assign hitLsTh = addr == `HC_CMD_LSTH;
  assign hitRhA = addr == `HC_CMD_RHA;
  assign hitRhB = addr == `HC_CMD_RHB;
  assign hitRhSt = addr == `HC_CMD_RHST;
  assign hitPort1 = addr == `HC_CMD_PORT1;
  assign hitPort2 = addr == `HC_CMD_PORT2;
  // Periodic and asynchronous list registers
  assign hitPDone = addr == `HC_CMD_PDONE;
  assign hitPSkip = addr == `HC_CMD_PSKIP;
  assign hitPLast = addr == `HC_CMD_PLAST;
  assign hitPAct = addr == `HC_CMD_PACT;
  assign hitADone = addr == `HC_CMD_ADONE;
  assign hitASkip = addr == `HC_CMD_ASKIP;
  assign hitALast = addr == `HC_CMD_ALAST;
  assign hitAAct = addr == `HC_CMD_AACT;
  // DMA, event, miscellaneous and buffer registers
  assign hitHwCfg = addr == `HC_CMD_HWCFG;
  assign hitDmaCfg = addr == `HC_CMD_DMACFG;
  assign hitXferCnt = addr == `HC_CMD_XFERCNT;
  assign hitCpuEv = addr == `HC_CMD_CPUEV;
  assign hitCpuEn = addr == `HC_CMD_CPUEN;
  assign hitPartId = addr == `HC_CMD_CHIPID;
  assign hitScratch = addr == `HC_CMD_SCRATCH;
  assign hitSwRst = addr == `HC_CMD_SWRST;
  assign hitBufSt = addr == `HC_CMD_BUFST;
  assign hitIsoLen = addr == `HC_CMD_ISOLEN;
  assign hitDaLen = addr == `HC_CMD_DALEN;
  assign hitPLen = addr == `HC_CMD_PLEN;
  assign hitALen = addr == `HC_CMD_ALEN;
  assign hitIso0Win = addr == `HC_CMD_ISO0WIN;
  assign hitIso1Win = addr == `HC_CMD_ISO1WIN;
  assign hitPWin = addr == `HC_CMD_PWIN;
  assign hitAWin = addr == `HC_CMD_AWIN;
  assign hitDaWord = addr == `HC_CMD_DAWORD;
  assign hitIsoRate = addr == `HC_CMD_ISORATE;
  assign hitADCnt = addr == `HC_CMD_ADCNT;
  assign hitADTime = addr == `HC_CMD_ADTIME;
  assign hitPBlk = addr == `HC_CMD_PBLK;
  assign hitABlk = addr == `HC_CMD_ABLK;

  // Width classes: operational set, list done/skip/last maps and DaLen 32 bit, the rest 16
  // widths follow the overview map
  assign isOper32 = hitRev || hitCtrl || hitCmdSt || hitEvFlg || hitEvSet || hitEvClr
    || hitFmInt || hitFmLeft || hitFmNum || hitLsTh || hitRhA || hitRhB || hitRhSt
    || hitPort1 || hitPort2;
  assign isList32 = hitPDone || hitPSkip || hitPLast
    || hitADone || hitASkip || hitALast;
  assign isWide = isOper32 || isList32 || hitDaLen;
  assign isNarrow = hitPAct || hitAAct || hitHwCfg || hitDmaCfg || hitXferCnt || hitCpuEv
    || hitCpuEn || hitPartId || hitScratch || hitBufSt || hitIsoLen || hitPLen || hitALen
    || hitIso0Win || hitIso1Win || hitPWin || hitAWin || hitDaWord || hitIsoRate
    || hitADCnt || hitADTime || hitPBlk || hitABlk;
  // decode of the compatible operational set and the rest
  assign isMapped = isWide || isNarrow;
  assign isRo = hitRev || hitPDone || hitPAct
    || hitADone || hitAAct || hitPartId;
  // one write per command, only to mapped, writable codes
  assign wrEn = take && isWrite && isMapped && !isRo;
  // narrow registers keep only 16 bits
  assign wrWord = isWide ? cmdPort.cmdWdata : {16'h0000, cmdPort.cmdWdata[15:0]};

  // Read data selection; status maps are fed by other logic and read zero here
  // revision constant, upper bits zero
  // narrow registers read zero above bit 15
  assign rdNarrow = {16'h0000, regMem_r[addr][15:0]};
  assign rdStored = isWide ? regMem_r[addr] : rdNarrow;
  assign rdVal = isWrite ? 32'h00000000 :
    hitRev ? {24'h000000, `HC_REV_VALUE} :
    hitPartId ? {16'h0000, CHIP_ID} :
    (!isMapped || isRo) ? 32'h00000000 :
    rdStored;

  // Storage update
  // No reset on storage: software programs a register before it relies on it
  // narrow registers keep 16 bits
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      regMem_r[addr] <= wrWord;
    end
  end

  // One-cycle answer and soft reset pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmdDone_r <= 1'b0;
      cmdRdata_r <= 32'h00000000;
      softReset_r <= 1'b0;
    end else begin
      cmdDone_r <= take;
      cmdRdata_r <= take ? rdVal : cmdRdata_r;
      softReset_r <= take && isWrite && hitSwRst;
    end
  end

  assign cmdPort.cmdDone = cmdDone_r;
  assign cmdPort.cmdRdata = cmdRdata_r;
  assign softResetPulse = softReset_r;
endmodule

/* rtl/hc_regs_defines.svh */
// Command codes, revision value and APB control layout of the host controller register bank
`ifndef HC_REGS_DEFINES_SVH
`define HC_REGS_DEFINES_SVH
`define HC_WR_FLAG 8'h80
`define HC_CMD_REV 7'h00
`define HC_CMD_CTRL 7'h01
`define HC_CMD_CMDST 7'h02
`define HC_CMD_EVFLG 7'h03
`define HC_CMD_EVSET 7'h04
`define HC_CMD_EVCLR 7'h05
`define HC_CMD_FMINT 7'h0d
`define HC_CMD_FMLEFT 7'h0e
`define HC_CMD_FMNUM 7'h0f
`define HC_CMD_LSTH 7'h11
`define HC_CMD_RHA 7'h12
`define HC_CMD_RHB 7'h13
`define HC_CMD_RHST 7'h14
`define HC_CMD_PORT1 7'h15
`define HC_CMD_PORT2 7'h16
`define HC_CMD_PDONE 7'h17
`define HC_CMD_PSKIP 7'h18
`define HC_CMD_PLAST 7'h19
`define HC_CMD_PACT 7'h1a
`define HC_CMD_ADONE 7'h1b
`define HC_CMD_ASKIP 7'h1c
`define HC_CMD_ALAST 7'h1d
`define HC_CMD_AACT 7'h1e
`define HC_CMD_DALEN 7'h32
`define HC_CMD_CHIPID 7'h27
`define HC_CMD_SWRST 7'h29
`define HC_CMD_HWCFG 7'h20
`define HC_CMD_DMACFG 7'h21
`define HC_CMD_XFERCNT 7'h22
`define HC_CMD_CPUEV 7'h24
`define HC_CMD_CPUEN 7'h25
`define HC_CMD_SCRATCH 7'h28
`define HC_CMD_BUFST 7'h2c
`define HC_CMD_ISOLEN 7'h30
`define HC_CMD_PLEN 7'h33
`define HC_CMD_ALEN 7'h34
`define HC_CMD_ISO0WIN 7'h40
`define HC_CMD_ISO1WIN 7'h42
`define HC_CMD_PWIN 7'h43
`define HC_CMD_AWIN 7'h44
`define HC_CMD_DAWORD 7'h45
`define HC_CMD_ISORATE 7'h47
`define HC_CMD_ADCNT 7'h51
`define HC_CMD_ADTIME 7'h52
`define HC_CMD_PBLK 7'h53
`define HC_CMD_ABLK 7'h54
// Arbitrary BCD version value
`define HC_REV_VALUE 8'h10
`define HC_REV_MSB 7
`define HC_OFFSET_DIV 4
`define APB_CTRL_OFS 12'h000
`define APB_STAT_OFS 12'h004
`define APB_WDATA_OFS 12'h008
`define APB_RDATA_OFS 12'h00c
`define CTRL_GO_BIT 0
`define CTRL_WR_BIT 1
`define CTRL_CMD_LSB 8
`define CTRL_CMD_MSB 15
`endif

/* rtl/hc_regs_pkg.sv */
// Types shared by both ends of the register command port
package hc_regs_pkg;
  typedef logic [7:0] cmd_t;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_DONE = 3'b100
  } host_state_t;
endpackage

/* verif/hc_regs_props.sv */
// Command port checks between host master and register bank
`timescale 1ns/1ps
module hc_regs_props #(
  parameter logic [15:0] CHIP_ID = 16'h5a5a // Arbitrary identification value
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic cmdValid, // Request level
  input wire hc_regs_pkg::cmd_t cmdCode, // Command code
  input wire hc_regs_pkg::word_t cmdWdata, // Write word
  input wire logic cmdDone, // Completion pulse
  input wire hc_regs_pkg::word_t cmdRdata // Read data
);
  import hc_regs_pkg::*;
  word_t ctrlCopy_r;
  logic [15:0] scrCopy_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Last words written to control and scratch
  always_ff @(posedge sys_clk) begin
    if (cmdDone && cmdCode == 8'h81) ctrlCopy_r <= cmdWdata;
    if (cmdDone && cmdCode == 8'ha8) scrCopy_r <= cmdWdata[15:0];
  end
  done_after_take_a: assert property (cmdValid && !cmdDone |=> cmdDone)
    else $error("command not answered in one cycle");
  done_single_a: assert property (cmdDone |=> !cmdDone)
    else $error("completion longer than one cycle");
  code_stable_a: assert property (cmdValid && !cmdDone |=> $stable(cmdCode))
    else $error("command code moved before completion");
  rev_value_a: assert property (cmdDone && cmdCode == 8'h00 |=> cmdRdata == 32'h10)
    else $error("revision value wrong");
  part_id_a: assert property (cmdDone && cmdCode == 8'h27 |=> cmdRdata == {16'h0, CHIP_ID})
    else $error("part code wrong");
  ctrl_back_a: assert property (cmdDone && cmdCode == 8'h01 |=> cmdRdata == ctrlCopy_r)
    else $error("control word not kept");
  narrow_back_a: assert property (cmdDone && cmdCode == 8'h28 |=> cmdRdata == {16'h0, scrCopy_r})
    else $error("scratch word not kept");
  unmapped_zero_a: assert property (cmdDone && cmdCode == 8'h06 |=> cmdRdata == 32'h0)
    else $error("unassigned code read not zero");
endmodule

/* verif/testbench.sv */
// APB-driven bench for host master and register bank
`timescale 1ns/1ps
`include "hc_regs_defines.svh"
module testbench;
  import hc_regs_pkg::*;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, swRst, errSeen;
  logic [11:0] paddr;
  word_t pwdata, prdata, rd, ex;
  int mismatches = 0, nTests = 0, swRstSeen = 0;
  // Bit 7 marks a narrow register
  logic [7:0] map[39] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1c, 8'h1d, 8'h32, 8'ha0, 8'ha1, 8'ha2, 8'ha4,
    8'ha5, 8'ha8, 8'hac, 8'hb0, 8'hb3, 8'hb4, 8'hc0, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc7, 8'hd1,
    8'hd2, 8'hd3, 8'hd4};
  logic [6:0] bad[4] = '{7'h00, 7'h06, 7'h27, 7'h1a};
  hc_cmd_if link();
  hc_reg_bank i_hc_reg_bank (.sys_clk, .nrst, .cmdPort(link), .softResetPulse(swRst));
  hc_host_master i_hc_host_master (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .cmdPort(link));
  hc_regs_props i_hc_regs_props (.sys_clk, .nrst, .cmdValid(link.cmdValid), .cmdCode(link.cmdCode),
    .cmdWdata(link.cmdWdata), .cmdDone(link.cmdDone), .cmdRdata(link.cmdRdata));
  // Clock and reset pulse count
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (swRst === 1'h1) swRstSeen++;
  function automatic word_t pat(input logic [6:0] a);
    return {1'h0, a, 8'h5c, 1'h1, a, 8'ha3};
  endfunction
  task automatic chk(input string s, input word_t e, input word_t g);
    nTests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input word_t d, output word_t q);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      wrap_up();
    end
    q = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  // One register command through the master
  task automatic cmd(input logic w, input logic [6:0] a, input word_t d, output word_t q);
    int n;
    n = 0;
    apb(1'h1, 12'h008, d, q);
    apb(1'h1, 12'h000, {16'h0, 1'h0, a, 6'h0, w, 1'h1}, q);
    do begin
      apb(1'h0, 12'h004, 32'h0, q);
      n++;
    end while (q[0] !== 1'h0 && n < 20);
    if (n >= 20) begin
      chk("busy", 32'h0, 32'h1);
      wrap_up();
    end
    apb(1'h0, 12'h00c, 32'h0, q);
  endtask
  // Main sequence
  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    foreach (map[i]) cmd(1'h1, map[i][6:0], pat(map[i][6:0]), rd);
    foreach (bad[i]) cmd(1'h1, bad[i], 32'hffffffff, rd);
    cmd(1'h0, 7'h00, 32'h0, rd);
    chk("revision", 32'h00000010, rd);
    cmd(1'h0, 7'h27, 32'h0, rd);
    chk("part code", 32'h00005a5a, rd);
    cmd(1'h0, 7'h06, 32'h0, rd);
    chk("unassigned read", 32'h0, rd);
    foreach (map[i]) begin
      ex = pat(map[i][6:0]);
      if (map[i][7]) ex[31:16] = 16'h0;
      cmd(1'h0, map[i][6:0], 32'h0, rd);
      chk("register", ex, rd);
    end
    // Driver habits: read-modify-write, shadow copy, set write, field-only compare
    cmd(1'h0, 7'h01, 32'h0, rd);
    cmd(1'h1, 7'h01, rd | 32'h00000600, rd);
    cmd(1'h0, 7'h01, 32'h0, rd);
    chk("modified control", pat(7'h01) | 32'h00000600, rd);
    ex = pat(7'h01) | 32'h00000600;
    ex[7:6] = 2'h1;
    cmd(1'h1, 7'h01, ex, rd);
    cmd(1'h0, 7'h01, 32'h0, rd);
    chk("shadow control", ex, rd);
    cmd(1'h1, 7'h04, 32'h00000040, rd);
    cmd(1'h0, 7'h04, 32'h0, rd);
    chk("set write", 32'h00000040, rd);
    cmd(1'h0, 7'h00, 32'h0, rd);
    chk("revision field", {24'h0, `HC_REV_VALUE}, {24'h0, rd[7:0]});
    cmd(1'h1, 7'h29, 32'h0, rd);
    chk("soft reset pulses", 32'h1, word_t'(swRstSeen));
    apb(1'h0, 12'h010, 32'h0, rd);
    chk("apb error", {31'h0, errSeen}, 32'h1);
    wrap_up();
  end
endmodule
